// ===== lpt_axil_slave.sv
// AXI4-Lite slave front end for the low-power periodic timer.
// Assumes a single-clock master; one write and one read under way at a time.
`timescale 1ns/1ps
`default_nettype none
module lpt_axil_slave
    import lpt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic [31:0] rd_addr,
    input wire logic [31:0] rd_data
);

    logic aw_have_q;
    logic w_have_q;
    logic rd_pend_q;

    // ************************************************************
    // Write channel
    // ************************************************************
    assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LPT_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_addr <= 32'h0000_0000;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= lpt_addr_known(wr_addr) ? LPT_RESP_OKAY : LPT_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= LPT_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            rd_pend_q <= 1'b0;
            rd_addr <= 32'h0000_0000;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rd_addr <= s_axi_araddr;
                rd_pend_q <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (rd_pend_q && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= lpt_addr_known(rd_addr) ? LPT_RESP_OKAY : LPT_RESP_SLVERR;
                rd_pend_q <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== lpt_pkg.sv
// Shared constants for the low-power periodic timer: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
package lpt_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    // Printed offsets are not word multiples, so they are kept as indices.
    localparam logic [31:0] LPT_IDX_CLOCK_GATE = 32'h0008_00B1;
    localparam logic [31:0] LPT_IDX_RUN_CLEAR = 32'h0008_00B2;
    localparam logic [31:0] LPT_IDX_PERIOD = 32'h0008_00B4;
    localparam logic [31:0] LPT_ADDR_CLOCK_GATE = LPT_IDX_CLOCK_GATE << 2;
    localparam logic [31:0] LPT_ADDR_RUN_CLEAR = LPT_IDX_RUN_CLEAR << 2;
    localparam logic [31:0] LPT_ADDR_PERIOD = LPT_IDX_PERIOD << 2;
    localparam logic [31:0] LPT_ADDR_UNLOCK = 32'h0000_0000;
    localparam logic [31:0] LPT_ADDR_CONTROL = 32'h0000_0004;
    localparam logic [31:0] LPT_ADDR_COMPARE = 32'h0000_0008;
    localparam logic [31:0] LPT_ADDR_IRQ_STATUS = 32'h0000_000C;
    localparam logic [31:0] LPT_ADDR_IRQ_MASK = 32'h0000_0010;
    localparam logic [31:0] LPT_ADDR_COUNT = 32'h0000_0014;

    // ************************************************************
    // Fields
    // ************************************************************
    localparam int LPT_BIT_GATE_OFF = 0;
    localparam int LPT_BIT_RUN = 0;
    localparam int LPT_BIT_CLEAR = 1;
    localparam int LPT_BIT_UNLOCK = 0;
    localparam int LPT_POS_PRESCALE = 0;
    localparam int LPT_BIT_SRC_SEL = 4;
    localparam int LPT_BIT_CMP_EN = 6;
    localparam int LPT_BIT_EV_CMP = 0;
    localparam int LPT_BIT_EV_WRAP = 1;
    localparam int LPT_NUM_EVENTS = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic LPT_RST_GATE_OFF = 1'h1;
    localparam logic [15:0] LPT_RST_PERIOD = 16'hFFFF;
    localparam logic [15:0] LPT_RST_COMPARE = 16'hFFFF;
    localparam logic [2:0] LPT_RST_PRESCALE = 3'h1;

    localparam logic [1:0] LPT_RESP_OKAY = 2'h0;
    localparam logic [1:0] LPT_RESP_SLVERR = 2'h2;

    // Last divider count for a prescale code; prohibited codes fall back to divide by 2.
    function automatic logic [4:0] lpt_div_last(input logic [2:0] code);
        logic [4:0] r;
        r = 5'h01;
        if (code >= 3'h1 && code <= 3'h5) begin
            r = 5'((6'h01 << code) - 6'h01);
        end
        return r;
    endfunction

    function automatic logic lpt_addr_known(input logic [31:0] a);
        return a == LPT_ADDR_CLOCK_GATE || a == LPT_ADDR_RUN_CLEAR || a == LPT_ADDR_PERIOD
            || a == LPT_ADDR_UNLOCK || a == LPT_ADDR_CONTROL || a == LPT_ADDR_COMPARE
            || a == LPT_ADDR_IRQ_STATUS || a == LPT_ADDR_IRQ_MASK || a == LPT_ADDR_COUNT;
    endfunction

    // Byte-lane merge of the low half word.
    function automatic logic [15:0] lpt_merge16(input logic [15:0] old, input logic [31:0] d,
                                                input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = d[7:0];
        end
        if (strb[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

endpackage

// ===== lpt_timer.sv
// Low-power periodic timer: registers, prescale divider, 16-bit counter, events.
// Assumes the source oscillators arrive as slow pins, at most a quarter of aclk.
//
// Summary of operation
// - Gate bit 1 withholds timer clock.
// - Reserved gate and run bits read zero.
// - Locked registers ignore writes without unlock.
// - Run bit enables counter and divider.
// - Clear bit one clears on timer clock.
// - Clear bit reads one until done.
// - Cycle is source times ratio times period+1.
// - Counter wraps to zero after period match.
// - Prescale codes 1..5 divide by 2..32.
// - Compare match fires only in standby.
`timescale 1ns/1ps
`default_nettype none
module lpt_timer
    import lpt_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sub_clock,
    input wire logic watchdog_oscillator,
    input wire logic standby_mode,
    output logic compare_match_event_q,
    output logic irq_q
);

    logic wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;

    logic write_unlock_bit_q;
    logic clock_gate_off_q;
    logic counter_run_q;
    logic counter_clear_request_q;
    logic [15:0] period_value_q;
    logic [15:0] compare_value_q;
    logic [2:0] prescale_select_q;
    logic source_clock_select_q;
    logic compare_enable_q;
    logic [LPT_NUM_EVENTS-1:0] irq_status_q;
    logic [LPT_NUM_EVENTS-1:0] irq_mask_q;
    logic [LPT_NUM_EVENTS-1:0] event_set;

    logic [1:0] sub_sync_q;
    logic [1:0] wdt_sync_q;
    logic src_level;
    logic src_prev_q;
    logic src_edge;
    logic [4:0] div_q;
    logic [COUNT_WIDTH-1:0] count_q;
    logic step;
    logic tick;
    logic clear_done;
    logic wrap;
    logic lane0;
    logic locked_write;

    lpt_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // ************************************************************
    // Register writes
    // ************************************************************
    assign lane0 = wr_en && wr_strb[0];
    // Gate, run/clear, control, period and compare registers accept a write only after software sets the unlock bit.
    assign locked_write = wr_en && write_unlock_bit_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            write_unlock_bit_q <= 1'b0;
        end else if (lane0 && wr_addr == LPT_ADDR_UNLOCK) begin
            write_unlock_bit_q <= wr_data[LPT_BIT_UNLOCK];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_gate_off_q <= LPT_RST_GATE_OFF;
            counter_run_q <= 1'b0;
            prescale_select_q <= LPT_RST_PRESCALE;
            source_clock_select_q <= 1'b0;
            compare_enable_q <= 1'b0;
        end else if (locked_write && wr_strb[0]) begin
            if (wr_addr == LPT_ADDR_CLOCK_GATE) begin
                clock_gate_off_q <= wr_data[LPT_BIT_GATE_OFF];
            end
            if (wr_addr == LPT_ADDR_RUN_CLEAR) begin
                counter_run_q <= wr_data[LPT_BIT_RUN];
            end
            if (wr_addr == LPT_ADDR_CONTROL) begin
                prescale_select_q <= wr_data[LPT_POS_PRESCALE +: 3];
                source_clock_select_q <= wr_data[LPT_BIT_SRC_SEL];
                compare_enable_q <= wr_data[LPT_BIT_CMP_EN];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_value_q <= LPT_RST_PERIOD;
            compare_value_q <= LPT_RST_COMPARE;
        end else if (locked_write) begin
            if (wr_addr == LPT_ADDR_PERIOD) begin
                period_value_q <= lpt_merge16(period_value_q, wr_data, wr_strb);
            end
            if (wr_addr == LPT_ADDR_COMPARE) begin
                compare_value_q <= lpt_merge16(compare_value_q, wr_data, wr_strb);
            end
        end
    end

    // A new request in the completion cycle wins, so no request is lost.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_clear_request_q <= 1'b0;
        end else if (locked_write && wr_strb[0] && wr_addr == LPT_ADDR_RUN_CLEAR
                     && wr_data[LPT_BIT_CLEAR]) begin
            counter_clear_request_q <= 1'b1;
        end else if (clear_done) begin
            counter_clear_request_q <= 1'b0;
        end
    end

    // ************************************************************
    // Source clock sampling
    // ************************************************************
    // Both oscillators are sampled twice before use; the edge detector reads
    // only the second stage.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub_sync_q <= 2'h0;
            wdt_sync_q <= 2'h0;
            src_prev_q <= 1'b0;
        end else begin
            sub_sync_q <= {sub_sync_q[0], sub_clock};
            wdt_sync_q <= {wdt_sync_q[0], watchdog_oscillator};
            src_prev_q <= src_level;
        end
    end

    assign src_level = source_clock_select_q ? wdt_sync_q[1] : sub_sync_q[1];
    assign src_edge = src_level && !src_prev_q;

    // ************************************************************
    // Divider and counter
    // ************************************************************
    assign clear_done = counter_clear_request_q && src_edge && !clock_gate_off_q;
    assign step = src_edge && !clock_gate_off_q && counter_run_q;
    assign tick = step && !clear_done && div_q == lpt_div_last(prescale_select_q);
    assign wrap = tick && count_q == COUNT_WIDTH'(period_value_q);

    // Gated, both stages keep their value; stopped, they keep it unless a pending clear completes and zeroes them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 5'h00;
        end else if (clear_done) begin
            div_q <= 5'h00;
        end else if (step) begin
            div_q <= tick ? 5'h00 : div_q + 5'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= '0;
        end else if (clear_done) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= wrap ? '0 : count_q + 1'b1;
        end
    end

    // ************************************************************
    // Events and interrupt
    // ************************************************************
    assign event_set[LPT_BIT_EV_CMP] = tick && compare_enable_q && standby_mode
                                       && count_q == COUNT_WIDTH'(compare_value_q);
    assign event_set[LPT_BIT_EV_WRAP] = wrap;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_match_event_q <= 1'b0;
        end else begin
            compare_match_event_q <= event_set[LPT_BIT_EV_CMP];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_q <= '0;
        end else if (lane0 && wr_addr == LPT_ADDR_IRQ_STATUS) begin
            irq_status_q <= (irq_status_q & ~wr_data[LPT_NUM_EVENTS-1:0]) | event_set;
        end else begin
            irq_status_q <= irq_status_q | event_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (lane0 && wr_addr == LPT_ADDR_IRQ_MASK) begin
                irq_mask_q <= wr_data[LPT_NUM_EVENTS-1:0];
            end
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            LPT_ADDR_CLOCK_GATE: rd_data[LPT_BIT_GATE_OFF] = clock_gate_off_q;
            LPT_ADDR_RUN_CLEAR: begin
                rd_data[LPT_BIT_RUN] = counter_run_q;
                rd_data[LPT_BIT_CLEAR] = counter_clear_request_q;
            end
            LPT_ADDR_PERIOD: rd_data[15:0] = period_value_q;
            LPT_ADDR_UNLOCK: rd_data[LPT_BIT_UNLOCK] = write_unlock_bit_q;
            LPT_ADDR_CONTROL: begin
                rd_data[LPT_POS_PRESCALE +: 3] = prescale_select_q;
                rd_data[LPT_BIT_SRC_SEL] = source_clock_select_q;
                rd_data[LPT_BIT_CMP_EN] = compare_enable_q;
            end
            LPT_ADDR_COMPARE: rd_data[15:0] = compare_value_q;
            LPT_ADDR_IRQ_STATUS: rd_data[LPT_NUM_EVENTS-1:0] = irq_status_q;
            LPT_ADDR_IRQ_MASK: rd_data[LPT_NUM_EVENTS-1:0] = irq_mask_q;
            LPT_ADDR_COUNT: rd_data[COUNT_WIDTH-1:0] = count_q;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_clear_asked;
        locked_write && wr_strb[0] && wr_addr == LPT_ADDR_RUN_CLEAR && wr_data[LPT_BIT_CLEAR];
    endsequence

    sequence s_clear_held;
        counter_clear_request_q [*2];
    endsequence

    AST_GATE_HOLDS: assert property (
        clock_gate_off_q |=> $stable(count_q) && $stable(div_q))
        else $error("Counter moved while clock gated.");
    AST_RESERVED_ZERO: assert property (
        rd_addr == LPT_ADDR_RUN_CLEAR |-> rd_data[31:2] == 30'h0)
        else $error("Reserved run bits not zero.");
    AST_LOCKED_IGNORED: assert property (
        wr_en && !write_unlock_bit_q && wr_addr == LPT_ADDR_PERIOD |=> $stable(period_value_q))
        else $error("Period changed while locked.");
    AST_STOP_HOLDS: assert property (
        !counter_run_q && !counter_clear_request_q |=> $stable(count_q) && $stable(div_q))
        else $error("Stopped counter moved.");
    AST_CLEAR_ZERO: assert property (
        clear_done |=> count_q == '0 && div_q == 5'h00 && !counter_clear_request_q)
        else $error("Clear did not zero counter.");
    AST_PENDING_STAYS: assert property (
        s_clear_asked ##1 (!src_edge || clock_gate_off_q) |-> s_clear_held)
        else $error("Clear flag dropped early.");
    AST_WRAP: assert property (
        tick && count_q == COUNT_WIDTH'(period_value_q) |=> count_q == '0)
        else $error("Counter did not wrap at period.");
    AST_RATIO: assert property (tick |-> div_q == lpt_div_last(prescale_select_q))
        else $error("Tick off divider ratio.");
    AST_CMP_STANDBY: assert property (
        compare_match_event_q |-> $past(standby_mode))
        else $error("Compare match outside standby.");
    AST_SYNC_EDGE: assert property (
        src_edge |-> !$past(src_level) || $changed(source_clock_select_q))
        else $error("Source edge not from synchronised level.");

endmodule
`default_nettype wire

// ===== lpt_timer_tb_top.sv
// Self-checking bench for the low-power periodic timer, driven over AXI4-Lite.
// Assumes lpt_pkg and lpt_timer are compiled first; sub_clock is made by the bench.
`timescale 1ns/1ps
`default_nettype none
module lpt_timer_tb_top;
    import lpt_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic sub_clock = 1'b0, wdt = 1'b0, standby = 1'b0, use_wdt = 1'b0;
    int cm_seen = 0;
    logic awready, wready, bvalid, arready, rvalid, cm_ev, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] d;
    int err_count = 0;
    int comparisons = 0;
    lpt_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sub_clock(sub_clock), .watchdog_oscillator(wdt),
        .standby_mode(standby), .compare_match_event_q(cm_ev), .irq_q(irq));
    initial begin
        forever #25 aclk = ~aclk;
    end
    // The compare pulse stands for one cycle only, so it is counted where it is settled.
    always @(negedge aclk) begin
        if (cm_ev === 1'b1) cm_seen++;
    end
    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic hung();
        err_count++;
        $display("[FAIL] bus answer expected 1 seen 0");
        tally_and_finish();
    endtask
    // Valid is dropped at the edge where ready was seen, so it stays up until taken.
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hung();
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        hung();
    endtask
    task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        chk(what, d, exp);
    endtask
    // Each source period is nine aclk cycles, well inside the aclk/4 limit.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge aclk);
            sub_clock <= !use_wdt;
            wdt <= use_wdt;
            repeat (4) @(posedge aclk);
            sub_clock <= 1'b0;
            wdt <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rchk("gate reset", LPT_ADDR_CLOCK_GATE, 32'h1);
        rchk("run reset", LPT_ADDR_RUN_CLEAR, 32'h0);
        rchk("period reset", LPT_ADDR_PERIOD, 32'hFFFF);
        rd(32'h0000_0020);
        chk("unmapped rresp", {30'h0, resp}, {30'h0, LPT_RESP_SLVERR});
        wr(32'h0000_0020, 32'h1);
        chk("unmapped bresp", {30'h0, resp}, {30'h0, LPT_RESP_SLVERR});
        $display("test reset done");
    endtask
    task automatic t_lock();
        wr(LPT_ADDR_PERIOD, 32'h3);
        wr(LPT_ADDR_CLOCK_GATE, 32'h0);
        rchk("locked period", LPT_ADDR_PERIOD, 32'hFFFF);
        rchk("locked gate", LPT_ADDR_CLOCK_GATE, 32'h1);
        wr(LPT_ADDR_UNLOCK, 32'h1);
        wr(LPT_ADDR_PERIOD, 32'h3);
        rchk("period", LPT_ADDR_PERIOD, 32'h3);
        wr(LPT_ADDR_CLOCK_GATE, 32'hFE);
        rchk("gate reserved", LPT_ADDR_CLOCK_GATE, 32'h0);
        wr(LPT_ADDR_RUN_CLEAR, 32'hFC);
        rchk("run reserved", LPT_ADDR_RUN_CLEAR, 32'h0);
        $display("test lock done");
    endtask
    task automatic t_count();
        wr(LPT_ADDR_IRQ_MASK, 32'h2);
        wr(LPT_ADDR_CLOCK_GATE, 32'h0);
        wr(LPT_ADDR_RUN_CLEAR, 32'h1);
        pulses(6);
        rchk("count 3", LPT_ADDR_COUNT, 32'h3);
        chk("irq idle", {31'h0, irq}, 32'h0);
        pulses(2);
        rchk("count wrap", LPT_ADDR_COUNT, 32'h0);
        rchk("wrap status", LPT_ADDR_IRQ_STATUS, 32'h2);
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(LPT_ADDR_IRQ_MASK, 32'h0);
        rd(LPT_ADDR_COUNT);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(LPT_ADDR_IRQ_STATUS, 32'h2);
        rchk("status w1c", LPT_ADDR_IRQ_STATUS, 32'h0);
        pulses(2);
        wr(LPT_ADDR_CLOCK_GATE, 32'h1);
        pulses(4);
        rchk("gated hold", LPT_ADDR_COUNT, 32'h1);
        wr(LPT_ADDR_CLOCK_GATE, 32'h0);
        wr(LPT_ADDR_RUN_CLEAR, 32'h0);
        pulses(4);
        rchk("stopped hold", LPT_ADDR_COUNT, 32'h1);
        $display("test count done");
    endtask
    task automatic t_clear();
        wr(LPT_ADDR_RUN_CLEAR, 32'h0);
        rchk("clear 0 no effect", LPT_ADDR_COUNT, 32'h1);
        wr(LPT_ADDR_RUN_CLEAR, 32'h2);
        rchk("clear pending", LPT_ADDR_RUN_CLEAR, 32'h2);
        pulses(1);
        rchk("clear done", LPT_ADDR_RUN_CLEAR, 32'h0);
        rchk("count cleared", LPT_ADDR_COUNT, 32'h0);
        $display("test clear done");
    endtask
    // Compare match on the watchdog source at divide by 4, in standby and then awake.
    task automatic t_cmp();
        wr(LPT_ADDR_CLOCK_GATE, 32'h1);
        wr(LPT_ADDR_CONTROL, 32'h52);
        wr(LPT_ADDR_COMPARE, 32'h1);
        wr(LPT_ADDR_CLOCK_GATE, 32'h0);
        wr(LPT_ADDR_RUN_CLEAR, 32'h1);
        standby <= 1'b1;
        use_wdt <= 1'b1;
        pulses(8);
        rchk("count div4", LPT_ADDR_COUNT, 32'h2);
        chk("match in standby", cm_seen, 32'h1);
        rchk("match status", LPT_ADDR_IRQ_STATUS, 32'h1);
        standby <= 1'b0;
        wr(LPT_ADDR_IRQ_STATUS, 32'h1);
        pulses(16);
        rchk("awake status", LPT_ADDR_IRQ_STATUS, 32'h2);
        chk("no match awake", cm_seen, 32'h1);
        wr(LPT_ADDR_RUN_CLEAR, 32'h0);
        wr(LPT_ADDR_RUN_CLEAR, 32'h2);
        pulses(1);
        rchk("wdt clear", LPT_ADDR_COUNT, 32'h0);
        $display("test compare done");
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_lock();
        t_count();
        t_clear();
        t_cmp();
        tally_and_finish();
    end
endmodule
`default_nettype wire
